// File: memory_region_attribute_remap_test.sv
// Self-checking bench for the system control and attribute remap block
`timescale 1ns/1ps
module memory_region_attribute_remap_test;
    localparam logic [31:0] NS_VAL = 32'h440A_26E4;
    localparam logic [31:0] S_VAL = 32'h0005_AAAA;
    localparam logic [31:0] LOW_VAL = 32'h4404_0044;
    localparam logic [31:0] HIGH_VAL = 32'hFF00_0444;
    localparam logic [31:0] SLOW_VAL = 32'h0444_0004;
    logic mclk, sys_rst, longDescFormat, secureConfigLockInput, lkSecure;
    logic lkRegionTypeBit0, lkCacheable, lkBufferable, lkShareable;
    logic [2:0] lkAttrIndex;
    logic cpValid, cpWrite, cpSecure, cpRdataValid, cpUndef;
    logic [2:0] cpOpc1, cpOpc2;
    logic [3:0] cpCrn, cpCrm;
    logic [31:0] cpWdata, cpRdata, rd;
    logic [1:0] cpPrivLevel, lkMemType;
    logic cacheEnable, alignCheckEnable, translationEnable, swapBusLock;
    logic lkMappedShare, lkOuterShare, ud, rv;
    logic [7:0] lkAttrByte;
    int errors = 0;
    int n_compared = 0;

    mrr_sysctl_remap uut (.mclk(mclk), .sys_rst(sys_rst), .cpValid(cpValid), .cpWrite(cpWrite),
        .cpOpc1(cpOpc1), .cpCrn(cpCrn), .cpCrm(cpCrm), .cpOpc2(cpOpc2), .cpWdata(cpWdata),
        .cpPrivLevel(cpPrivLevel), .cpSecure(cpSecure), .longDescFormat(longDescFormat),
        .secureConfigLockInput(secureConfigLockInput), .lkRegionTypeBit0(lkRegionTypeBit0),
        .lkCacheable(lkCacheable), .lkBufferable(lkBufferable), .lkShareable(lkShareable),
        .lkAttrIndex(lkAttrIndex), .lkSecure(lkSecure), .cpRdata(cpRdata), .cpRdataValid(cpRdataValid),
        .cpUndef(cpUndef), .cacheEnable(cacheEnable), .alignCheckEnable(alignCheckEnable),
        .translationEnable(translationEnable), .swapBusLock(swapBusLock), .lkMemType(lkMemType),
        .lkMappedShare(lkMappedShare), .lkOuterShare(lkOuterShare), .lkAttrByte(lkAttrByte));

    mrr_core_model core (.mclk(mclk), .cpRdata(cpRdata), .cpRdataValid(cpRdataValid), .cpUndef(cpUndef),
        .cpValid(cpValid), .cpWrite(cpWrite), .cpOpc1(cpOpc1), .cpCrn(cpCrn), .cpCrm(cpCrm),
        .cpOpc2(cpOpc2), .cpWdata(cpWdata), .cpPrivLevel(cpPrivLevel), .cpSecure(cpSecure));

    // ------------------------------------------------------------
    // Clock, watchdog and reporting
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #100000;
        errors++;
        test_done();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Register moves: 0 control word, 1 remap or low, 2 normal or high
    // ------------------------------------------------------------
    task automatic mv(input logic w, input int sel, input logic [1:0] pl, input logic s, input logic [31:0] d);
        core.move(w, sel == 0 ? mrr_pkg::CRN_SYSCTL : mrr_pkg::CRN_REMAP,
                  sel == 0 ? mrr_pkg::CRM_SYSCTL : mrr_pkg::CRM_REMAP,
                  sel == 2 ? mrr_pkg::OPC2_SECOND : mrr_pkg::OPC2_FIRST, pl, s, d, rd, ud, rv);
    endtask : mv

    task automatic rdchk(input int sel, input logic s, input logic [31:0] exp);
        mv(1'b0, sel, 2'h1, s, 32'h0);
        check({ud, rv}, 2'h1);
        check(rd, exp);
    endtask : rdchk

    // ------------------------------------------------------------
    // Lookups, settled 1 ns after the inputs change
    // ------------------------------------------------------------
    task automatic lookShort(input logic [31:0] r, input logic sec);
        logic [1:0] t;
        logic sh;
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk);
            {lkRegionTypeBit0, lkCacheable, lkBufferable, lkShareable} = i[3:0];
            // Long index held wrong so a mix-up shows
            lkAttrIndex = ~i[3:1];
            lkSecure = sec;
            #1;
            t = r[2 * i[3:1] +: 2];
            sh = (t == mrr_pkg::MT_STRONG) | ((t == mrr_pkg::MT_DEVICE) & i[0] & r[17]) |
                 ((t == mrr_pkg::MT_NORMAL) & (i[0] ? r[19] : r[18]));
            check(lkMemType, t);
            check(lkMappedShare, sh);
            check(lkOuterShare, (t == mrr_pkg::MT_STRONG) | ((t == mrr_pkg::MT_NORMAL) & sh & ~r[24 + i[3:1]]));
        end
    endtask : lookShort

    task automatic lookLong(input logic [63:0] a, input logic sec);
        logic [7:0] b;
        logic [1:0] t;
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            lkAttrIndex = i[2:0];
            {lkRegionTypeBit0, lkCacheable, lkBufferable} = ~i[2:0];
            lkShareable = i[0];
            lkSecure = sec;
            #1;
            b = a[8 * i +: 8];
            check(lkAttrByte, b);
            t = b == 8'h00 ? mrr_pkg::MT_STRONG : (b[7:4] == 4'h0 ? mrr_pkg::MT_DEVICE : mrr_pkg::MT_NORMAL);
            check(lkMemType, t);
            check({lkMappedShare, lkOuterShare}, {i[0], 1'b0});
        end
    endtask : lookLong

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst, longDescFormat, secureConfigLockInput, lkSecure} = 4'h8;
        {lkRegionTypeBit0, lkCacheable, lkBufferable, lkShareable, lkAttrIndex} = 7'h00;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        check({cacheEnable, alignCheckEnable, translationEnable, swapBusLock}, 4'h0);
        rdchk(0, 1'b0, mrr_pkg::SC_ONES_MASK);
        for (int i = 0; i < 3; i++) begin
            mv(1'b1, 0, 2'h1, 1'b0, 32'h1 << i);
            check({cacheEnable, alignCheckEnable, translationEnable}, 3'h1 << i);
            rdchk(0, 1'b0, mrr_pkg::SC_ONES_MASK | (32'h1 << i));
        end
        mv(1'b1, 0, 2'h0, 1'b0, 32'h7);
        check({ud, cacheEnable, alignCheckEnable, translationEnable, swapBusLock}, 5'h18);
        mv(1'b1, 1, 2'h1, 1'b0, 32'hFFFF_FFFF);
        mv(1'b1, 1, 2'h1, 1'b1, S_VAL);
        rdchk(1, 1'b0, 32'hFFFF_FFFF);
        rdchk(1, 1'b1, S_VAL);
        mv(1'b0, 1, 2'h0, 1'b0, 32'h0);
        check(ud, 1'b1);
        secureConfigLockInput = 1'b1;
        repeat (6) @(negedge mclk);
        mv(1'b1, 1, 2'h1, 1'b1, 32'h0);
        mv(1'b1, 1, 2'h1, 1'b0, NS_VAL);
        rdchk(1, 1'b1, S_VAL);
        rdchk(1, 1'b0, NS_VAL);
        secureConfigLockInput = 1'b0;
        repeat (6) @(negedge mclk);
        lookShort(NS_VAL, 1'b0);
        lookShort(S_VAL, 1'b1);
        @(negedge mclk);
        longDescFormat = 1'b1;
        mv(1'b0, 1, 2'h1, 1'b0, 32'h0);
        check(ud, 1'b0);
        mv(1'b1, 1, 2'h1, 1'b0, LOW_VAL);
        mv(1'b1, 2, 2'h1, 1'b0, HIGH_VAL);
        mv(1'b1, 1, 2'h1, 1'b1, SLOW_VAL);
        rdchk(2, 1'b0, HIGH_VAL);
        rdchk(1, 1'b1, SLOW_VAL);
        mv(1'b0, 2, 2'h0, 1'b0, 32'h0);
        check(ud, 1'b1);
        lookLong({HIGH_VAL, LOW_VAL}, 1'b0);
        lookLong({32'h0, SLOW_VAL}, 1'b1);
        @(negedge mclk);
        longDescFormat = 1'b0;
        rdchk(1, 1'b0, NS_VAL);
        test_done();
    end
endmodule : memory_region_attribute_remap_test

// File: mrr_attr_if.sv
// Lookup carrier between the register file and the attribute decoder
`timescale 1ns/1ps
interface mrr_attr_if;
    logic [31:0] remap;
    logic [31:0] normalRemap;
    logic [31:0] attrLow;
    logic [31:0] attrHigh;
    logic longFmt;
    logic [2:0] index;
    logic shareBit;
    logic [1:0] memType;
    logic mappedShare;
    logic outerShare;
    logic [7:0] attrByte;
    modport regs (output remap, normalRemap, attrLow, attrHigh, longFmt, index, shareBit,
                  input memType, mappedShare, outerShare, attrByte);
    modport lookup (input remap, normalRemap, attrLow, attrHigh, longFmt, index, shareBit,
                    output memType, mappedShare, outerShare, attrByte);
endinterface : mrr_attr_if

// File: mrr_attr_lookup.sv
// Combinational attribute remap for short and long descriptor formats
`timescale 1ns/1ps
module mrr_attr_lookup (
    mrr_attr_if.lookup lk
);
    logic [1:0] typeField;
    logic nosBit;
    logic [4:0] nosPos;
    logic [31:0] attrWord;
    logic [7:0] attrSel;

    always_comb begin
        typeField = lk.remap[{lk.index, 1'b0} +: 2];
        nosPos = mrr_pkg::NOS_BASE + {2'h0, lk.index};
        nosBit = lk.remap[nosPos];
        attrWord = lk.index[2] ? lk.attrHigh : lk.attrLow;
        attrSel = attrWord[{lk.index[1:0], 3'h0} +: 8];
        lk.memType = typeField;
        lk.mappedShare = 1'b0;
        lk.outerShare = 1'b0;
        lk.attrByte = 8'h00;
        if (lk.longFmt) begin
            // Indirection registers replace both remap registers
            lk.attrByte = attrSel;
            lk.mappedShare = lk.shareBit;
            if (attrSel[7:4] != mrr_pkg::ATTR_DEV_NIB) begin
                lk.memType = mrr_pkg::MT_NORMAL;
            end else if (attrSel[3:0] == mrr_pkg::ATTR_SO_NIB) begin
                lk.memType = mrr_pkg::MT_STRONG;
            end else begin
                lk.memType = mrr_pkg::MT_DEVICE;
            end
        end else begin
            unique case (typeField)
                mrr_pkg::MT_NORMAL: begin
                    lk.mappedShare = lk.shareBit ? lk.remap[mrr_pkg::NS_ONE_BIT]
                                                 : lk.remap[mrr_pkg::NS_ZERO_BIT];
                    lk.outerShare = lk.mappedShare && !nosBit;
                end
                // Bit 16 deliberately not consulted: unshared device stays unshared
                mrr_pkg::MT_DEVICE: lk.mappedShare = lk.shareBit && lk.remap[mrr_pkg::DS_ONE_BIT];
                mrr_pkg::MT_STRONG: begin
                    lk.mappedShare = 1'b1;
                    lk.outerShare = 1'b1;
                end
                default: lk.mappedShare = 1'b0;
            endcase
        end
    end
endmodule : mrr_attr_lookup

// File: mrr_bank_reg.sv
// Banked 32-bit register with a Secure and a Non-secure copy
`timescale 1ns/1ps
module mrr_bank_reg #(
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire logic wrSecure,
    input wire logic secureLock,
    input wire logic [31:0] wrData,
    output logic [31:0] secValue,
    output logic [31:0] nsValue
);
    logic [31:0] sec_q, sec_d, ns_q, ns_d;

    always_comb begin
        sec_d = sec_q;
        ns_d = ns_q;
        if (wrEn && wrSecure && !secureLock) begin
            sec_d = wrData;
        end
        if (wrEn && !wrSecure) begin
            ns_d = wrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sec_q <= RESET_VALUE;
            ns_q <= RESET_VALUE;
        end else begin
            sec_q <= sec_d;
            ns_q <= ns_d;
        end
    end

    assign secValue = sec_q;
    assign nsValue = ns_q;

    chk_secure_locked: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrEn && wrSecure && secureLock) |=> $stable(sec_q))
        else $error("Secure copy changed while locked");
    chk_secure_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrEn && wrSecure && !secureLock) |=> (sec_q == $past(wrData)) && $stable(ns_q))
        else $error("Secure write not taken or leaked");
endmodule : mrr_bank_reg

// File: mrr_core_model.sv
// Processor core model issuing coprocessor register moves
`timescale 1ns/1ps
module mrr_core_model (
    input wire logic mclk,
    input wire logic [31:0] cpRdata,
    input wire logic cpRdataValid,
    input wire logic cpUndef,
    output logic cpValid,
    output logic cpWrite,
    output logic [2:0] cpOpc1,
    output logic [3:0] cpCrn,
    output logic [3:0] cpCrm,
    output logic [2:0] cpOpc2,
    output logic [31:0] cpWdata,
    output logic [1:0] cpPrivLevel,
    output logic cpSecure
);
    initial begin
        {cpValid, cpWrite, cpOpc1, cpCrn, cpCrm, cpOpc2, cpWdata, cpPrivLevel, cpSecure} = '0;
    end

    // One move, held from a falling edge across the taking edge
    task automatic move(input logic w, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] opc2,
                        input logic [1:0] pl, input logic s, input logic [31:0] d,
                        output logic [31:0] rdata, output logic undef, output logic rvalid);
        @(negedge mclk);
        {cpValid, cpWrite, cpOpc1, cpCrn, cpCrm, cpOpc2} = {1'b1, w, mrr_pkg::OPC1_SYS, crn, crm, opc2};
        {cpWdata, cpPrivLevel, cpSecure} = {d, pl, s};
        #1;
        undef = cpUndef;
        @(negedge mclk);
        rvalid = cpRdataValid;
        rdata = cpRdata;
        cpValid = 1'b0;
        // Released fields stop showing the old move
        cpWdata = ~d;
        cpCrn = ~crn;
    endtask : move
endmodule : mrr_core_model

// File: mrr_pkg.sv
// Constants shared by the attribute remap and system control logic
//
// Contract
// - Cache enable bit globally enables data and unified caches; resets to 0.
// - Alignment fault checking runs only while the alignment bit is 1; resets 0.
// - Stage 1 translation runs only while the translation bit is 1; resets 0.
// - Swap and swap-byte instructions never cause bus-locked transfers.
// - System control word is read and written at opc1 0, c1, c0, opc2 0.
// - Primary remap needs privilege one or more and short-descriptor format.
// - Remap is banked; Secure copy writes are blocked while lock is high.
// - Bit 24+n selects Outer (0) or Inner (1) for Normal Shareable regions.
// - Bit 19 gives Normal shareability when the shareable attribute is 1.
// - Bit 18 gives Normal shareability when the shareable attribute is 0.
// - Bit 17 gives Device shareability when the shareable attribute is 1.
// - Bit 16 is stored but does not affect behaviour.
// - Field 2n+1:2n maps type: 00 strongly-ordered, 01 device, 10 normal.
// - Index n is {type bit 0, cacheable, bufferable}, 0 to 7.
// - Long format uses indirection low and high instead of both remap registers.
// - Primary remap is reached at opc1 0, c10, c2, opc2 0.
// - Indirection registers give attribute bytes for long-format index values.
// - Indirection registers need privilege one or more and long format.
// - Secure lookups use Secure copies; Non-secure lookups use Non-secure copies.
// - Index bit 2 selects high register; bits 1:0 select the byte lane.
package mrr_pkg;
    // ------------------------------------------------------------
    // Coprocessor move encodings
    // ------------------------------------------------------------
    localparam logic [2:0] OPC1_SYS = 3'h0;
    localparam logic [3:0] CRN_SYSCTL = 4'h1;
    localparam logic [3:0] CRM_SYSCTL = 4'h0;
    localparam logic [3:0] CRN_REMAP = 4'hA;
    localparam logic [3:0] CRM_REMAP = 4'h2;
    localparam logic [2:0] OPC2_FIRST = 3'h0;
    localparam logic [2:0] OPC2_SECOND = 3'h1;
    localparam logic [1:0] PRIV_USER = 2'h0;
    // ------------------------------------------------------------
    // System control word layout
    // ------------------------------------------------------------
    localparam int SC_TRANSLATE = 0;
    localparam int SC_ALIGN = 1;
    localparam int SC_CACHE = 2;
    localparam logic [31:0] SC_WRITE_MASK = 32'h0018_1407;
    localparam logic [31:0] SC_ONES_MASK = 32'h00C5_0878;
    localparam logic [31:0] SC_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // Remap layout and memory type codes
    // ------------------------------------------------------------
    localparam logic [4:0] NOS_BASE = 5'h18;
    localparam int NS_ONE_BIT = 19;
    localparam int NS_ZERO_BIT = 18;
    localparam int DS_ONE_BIT = 17;
    localparam int DS_ZERO_BIT = 16;
    localparam logic [31:0] REMAP_RESET = 32'h0000_0000;
    localparam logic [1:0] MT_STRONG = 2'h0;
    localparam logic [1:0] MT_DEVICE = 2'h1;
    localparam logic [1:0] MT_NORMAL = 2'h2;
    localparam logic [3:0] ATTR_DEV_NIB = 4'h0;
    localparam logic [3:0] ATTR_SO_NIB = 4'h0;
endpackage : mrr_pkg

// File: mrr_sysctl_remap.sv
// System control word and memory region attribute remap registers
`timescale 1ns/1ps
module mrr_sysctl_remap (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cpValid,
    input wire logic cpWrite,
    input wire logic [2:0] cpOpc1,
    input wire logic [3:0] cpCrn,
    input wire logic [3:0] cpCrm,
    input wire logic [2:0] cpOpc2,
    input wire logic [31:0] cpWdata,
    input wire logic [1:0] cpPrivLevel,
    input wire logic cpSecure,
    input wire logic longDescFormat,
    input wire logic secureConfigLockInput,
    input wire logic lkRegionTypeBit0,
    input wire logic lkCacheable,
    input wire logic lkBufferable,
    input wire logic lkShareable,
    input wire logic [2:0] lkAttrIndex,
    input wire logic lkSecure,
    output logic [31:0] cpRdata,
    output logic cpRdataValid,
    output logic cpUndef,
    output logic cacheEnable,
    output logic alignCheckEnable,
    output logic translationEnable,
    output logic swapBusLock,
    output logic [1:0] lkMemType,
    output logic lkMappedShare,
    output logic lkOuterShare,
    output logic [7:0] lkAttrByte
);
    // ------------------------------------------------------------
    // Lock pin synchroniser
    // ------------------------------------------------------------
    logic lockS1_q, lockS1_d;
    logic lockS2_q, lockS2_d;
    logic lockS3_q, lockS3_d;
    logic lock_q, lock_d;

    always_comb begin
        lockS1_d = secureConfigLockInput;
        lockS2_d = lockS1_q;
        lockS3_d = lockS2_q;
        lock_d = lock_q;
        // Act only once two samples agree, filters a single glitch
        if (lockS2_q == lockS3_q) begin
            lock_d = lockS3_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lockS1_q <= 1'b0;
            lockS2_q <= 1'b0;
            lockS3_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            lockS1_q <= lockS1_d;
            lockS2_q <= lockS2_d;
            lockS3_q <= lockS3_d;
            lock_q <= lock_d;
        end
    end

    // ------------------------------------------------------------
    // Move decode
    // ------------------------------------------------------------
    logic hitSysctl, hitFirst, hitSecond, privOk;
    logic accSysctl, accRemap, accNormal, accAttrLo, accAttrHi;

    always_comb begin
        hitSysctl = cpOpc1 == mrr_pkg::OPC1_SYS && cpCrn == mrr_pkg::CRN_SYSCTL
                    && cpCrm == mrr_pkg::CRM_SYSCTL && cpOpc2 == mrr_pkg::OPC2_FIRST;
        hitFirst = cpOpc1 == mrr_pkg::OPC1_SYS && cpCrn == mrr_pkg::CRN_REMAP
                   && cpCrm == mrr_pkg::CRM_REMAP && cpOpc2 == mrr_pkg::OPC2_FIRST;
        hitSecond = cpOpc1 == mrr_pkg::OPC1_SYS && cpCrn == mrr_pkg::CRN_REMAP
                    && cpCrm == mrr_pkg::CRM_REMAP && cpOpc2 == mrr_pkg::OPC2_SECOND;
        privOk = cpPrivLevel != mrr_pkg::PRIV_USER;
        accSysctl = cpValid && hitSysctl && privOk;
        accRemap = cpValid && hitFirst && privOk && !longDescFormat;
        accNormal = cpValid && hitSecond && privOk && !longDescFormat;
        accAttrLo = cpValid && hitFirst && privOk && longDescFormat;
        accAttrHi = cpValid && hitSecond && privOk && longDescFormat;
    end

    // Anything not taken traps to the core as undefined
    assign cpUndef = cpValid && !(accSysctl || accRemap || accNormal || accAttrLo || accAttrHi);

    // ------------------------------------------------------------
    // System control word
    // ------------------------------------------------------------
    logic [31:0] sysctl_q, sysctl_d;
    logic [31:0] sysctlView;

    always_comb begin
        sysctl_d = sysctl_q;
        if (accSysctl && cpWrite) begin
            sysctl_d = cpWdata & mrr_pkg::SC_WRITE_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sysctl_q <= mrr_pkg::SC_RESET;
        end else begin
            sysctl_q <= sysctl_d;
        end
    end

    assign sysctlView = sysctl_q | mrr_pkg::SC_ONES_MASK;
    assign cacheEnable = sysctl_q[mrr_pkg::SC_CACHE];
    assign alignCheckEnable = sysctl_q[mrr_pkg::SC_ALIGN];
    assign translationEnable = sysctl_q[mrr_pkg::SC_TRANSLATE];
    // Swaps run as plain read then write; no locked bus cycle ever
    assign swapBusLock = 1'b0;

    // ------------------------------------------------------------
    // Banked remap and indirection registers
    // ------------------------------------------------------------
    logic [31:0] remapSec, remapNs, normalSec, normalNs;
    logic [31:0] attrLoSec, attrLoNs, attrHiSec, attrHiNs;

    mrr_bank_reg #(.RESET_VALUE(mrr_pkg::REMAP_RESET)) remapBank (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(accRemap && cpWrite),
        .wrSecure(cpSecure),
        .secureLock(lock_q),
        .wrData(cpWdata),
        .secValue(remapSec),
        .nsValue(remapNs)
    );

    mrr_bank_reg #(.RESET_VALUE(mrr_pkg::REMAP_RESET)) normalBank (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(accNormal && cpWrite),
        .wrSecure(cpSecure),
        .secureLock(lock_q),
        .wrData(cpWdata),
        .secValue(normalSec),
        .nsValue(normalNs)
    );

    mrr_bank_reg #(.RESET_VALUE(mrr_pkg::REMAP_RESET)) attrLoBank (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(accAttrLo && cpWrite),
        .wrSecure(cpSecure),
        .secureLock(lock_q),
        .wrData(cpWdata),
        .secValue(attrLoSec),
        .nsValue(attrLoNs)
    );

    mrr_bank_reg #(.RESET_VALUE(mrr_pkg::REMAP_RESET)) attrHiBank (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(accAttrHi && cpWrite),
        .wrSecure(cpSecure),
        .secureLock(lock_q),
        .wrData(cpWdata),
        .secValue(attrHiSec),
        .nsValue(attrHiNs)
    );

    // ------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (cpValid && !cpWrite && !cpUndef) begin
            rvalid_d = 1'b1;
            unique case (1'b1)
                accSysctl: rdata_d = sysctlView;
                accRemap: rdata_d = cpSecure ? remapSec : remapNs;
                accNormal: rdata_d = cpSecure ? normalSec : normalNs;
                accAttrLo: rdata_d = cpSecure ? attrLoSec : attrLoNs;
                accAttrHi: rdata_d = cpSecure ? attrHiSec : attrHiNs;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cpRdata = rdata_q;
    assign cpRdataValid = rvalid_q;

    // ------------------------------------------------------------
    // Attribute lookup
    // ------------------------------------------------------------
    mrr_attr_if attrBus ();

    always_comb begin
        attrBus.remap = lkSecure ? remapSec : remapNs;
        attrBus.normalRemap = lkSecure ? normalSec : normalNs;
        attrBus.attrLow = lkSecure ? attrLoSec : attrLoNs;
        attrBus.attrHigh = lkSecure ? attrHiSec : attrHiNs;
        attrBus.longFmt = longDescFormat;
        attrBus.index = longDescFormat ? lkAttrIndex
                                       : {lkRegionTypeBit0, lkCacheable, lkBufferable};
        attrBus.shareBit = lkShareable;
    end

    mrr_attr_lookup attrDecode (
        .lk(attrBus.lookup)
    );

    assign lkMemType = attrBus.memType;
    assign lkMappedShare = attrBus.mappedShare;
    assign lkOuterShare = attrBus.outerShare;
    assign lkAttrByte = attrBus.attrByte;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_enables_reset: assert property (@(posedge mclk)
        sys_rst |=> !cacheEnable && !alignCheckEnable && !translationEnable)
        else $error("Enables not clear after reset");

    chk_cache_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (accSysctl && cpWrite) |=> cacheEnable == $past(cpWdata[mrr_pkg::SC_CACHE]))
        else $error("Cache enable did not follow write");

    chk_align_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (accSysctl && cpWrite) |=> alignCheckEnable == $past(cpWdata[mrr_pkg::SC_ALIGN]))
        else $error("Alignment enable did not follow write");

    chk_xlat_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (accSysctl && cpWrite) |=> translationEnable == $past(cpWdata[mrr_pkg::SC_TRANSLATE]))
        else $error("Translation enable did not follow write");

    chk_xlat_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !(accSysctl && cpWrite) |=> $stable(translationEnable))
        else $error("Translation enable moved without write");

    chk_no_lock: assert property (@(posedge mclk) disable iff (sys_rst)
        !swapBusLock)
        else $error("Locked transfer requested");

    chk_sysctl_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (accSysctl && !cpWrite) |=> cpRdataValid && cpRdata == $past(sysctlView))
        else $error("System control read wrong");

    chk_read_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        !(cpValid && !cpWrite && !cpUndef) |=> !cpRdataValid)
        else $error("Read valid without a taken read");

    chk_remap_guard: assert property (@(posedge mclk) disable iff (sys_rst)
        (cpValid && hitFirst && (cpPrivLevel == mrr_pkg::PRIV_USER)) |-> cpUndef ##1 !cpRdataValid)
        else $error("Remap reachable without privilege");

    chk_user_refused: assert property (@(posedge mclk) disable iff (sys_rst)
        (cpValid && !privOk) |-> cpUndef)
        else $error("Unprivileged move not refused");

    chk_remap_long: assert property (@(posedge mclk) disable iff (sys_rst)
        (cpValid && hitFirst && privOk) |-> (accRemap != longDescFormat) && (accAttrLo == longDescFormat))
        else $error("Format gate wrong");

    chk_remap_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (accRemap && !cpWrite && !cpSecure) |=> cpRdata == $past(remapNs))
        else $error("Remap read wrong");

    chk_type_map: assert property (@(posedge mclk) disable iff (sys_rst)
        !longDescFormat |-> lkMemType == attrBus.remap[{lkRegionTypeBit0, lkCacheable, lkBufferable, 1'b0} +: 2])
        else $error("Memory type mismatch");

    chk_normal_share: assert property (@(posedge mclk) disable iff (sys_rst)
        (!longDescFormat && lkMemType == mrr_pkg::MT_NORMAL)
        |-> lkMappedShare == attrBus.remap[lkShareable ? mrr_pkg::NS_ONE_BIT : mrr_pkg::NS_ZERO_BIT])
        else $error("Normal shareability mismatch");

    chk_device_share: assert property (@(posedge mclk) disable iff (sys_rst)
        (!longDescFormat && lkMemType == mrr_pkg::MT_DEVICE)
        |-> lkMappedShare == (lkShareable && attrBus.remap[mrr_pkg::DS_ONE_BIT]) && !lkOuterShare)
        else $error("Device shareability mismatch");

    chk_attr_byte: assert property (@(posedge mclk) disable iff (sys_rst)
        (longDescFormat && lkAttrIndex == 3'h5) |-> lkAttrByte == attrBus.attrHigh[15:8])
        else $error("Attribute byte lane wrong");

    chk_long_strong: assert property (@(posedge mclk) disable iff (sys_rst)
        (longDescFormat && lkMemType == mrr_pkg::MT_STRONG)
        |-> lkAttrByte == {mrr_pkg::ATTR_DEV_NIB, mrr_pkg::ATTR_SO_NIB})
        else $error("Strongly-ordered from a non-zero attribute");

    chk_lock_agree: assert property (@(posedge mclk) disable iff (sys_rst)
        (lockS2_q == lockS3_q) |=> lock_q == $past(lockS3_q))
        else $error("Lock did not follow agreeing samples");
endmodule : mrr_sysctl_remap
